// ==== logic/peg_gear_core.sv ====
// The plain strobed port and the register addresses were decided locally.
`include "peg_regs.svh"
module peg_gear_core import peg_pkg::*; #(
  parameter int ERR_W = 32,
  parameter int FB_W = 8
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic reference_pulse_input,
  input wire logic reference_direction,
  input wire logic error_clear_n,
  input wire logic servo_on,
  input wire logic over_travel,
  input wire logic zero_clamp_stop,
  input wire logic signed [FB_W-1:0] feedback_counts,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic signed [ERR_W-1:0] position_error,
  output logic loop_enable,
  output logic pulse_refused
);
  ////////////////////////////////////////////////////////////////
  // Registers seen by software
  // Writes land in staged copies only; the gear in use changes at a
  // restart, so a half-written ratio never reaches the motion path.
  logic [15:0] gear16_numerator_reg; // Staged 16-bit numerator
  logic [15:0] gear16_denominator_reg; // Staged 16-bit denominator
  logic [15:0] gear32_numerator_high_reg; // Staged decimal high and low parts
  logic [15:0] gear32_numerator_low_reg;
  logic [15:0] gear32_denominator_high_reg;
  logic [15:0] gear32_denominator_low_reg;
  logic [2:0] config_reg; // Clear mode and gear width select
  // Active copies, loaded only on restart so edits never disturb motion
  logic [31:0] act_num_reg;
  logic [31:0] act_den_reg;
  peg_clr_mode_t act_mode_reg;
  logic restart_req_reg; // Restart pending until gear is idle

  ////////////////////////////////////////////////////////////////
  // Composed ratio terms
  logic [31:0] num16_w;
  logic [31:0] den16_w;
  logic [31:0] num32_w;
  logic [31:0] den32_w;
  assign num16_w = {16'h0000, gear16_numerator_reg};
  assign den16_w = {16'h0000, gear16_denominator_reg};
  // Both pairs are widened to 32 bits so restart picks either one with a
  // single assignment; the 16-bit pair needs no arithmetic at all.
  // High times 10000 plus low, fits easily in 32 bits for parts up to 9999
  assign num32_w = 32'({16'h0000, gear32_numerator_high_reg} * `PEG_DEC_WEIGHT)
                   + {16'h0000, gear32_numerator_low_reg};
  assign den32_w = 32'({16'h0000, gear32_denominator_high_reg} * `PEG_DEC_WEIGHT)
                   + {16'h0000, gear32_denominator_low_reg};

  ////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      gear16_numerator_reg <= `PEG_RST_G16_NUM;
      gear16_denominator_reg <= `PEG_RST_G16_DEN;
      gear32_numerator_high_reg <= `PEG_RST_G32_HI;
      gear32_numerator_low_reg <= `PEG_RST_G32_LO;
      gear32_denominator_high_reg <= `PEG_RST_G32_HI;
      gear32_denominator_low_reg <= `PEG_RST_G32_LO;
      config_reg <= `PEG_RST_CONFIG;
    end else if (reg_write) begin
      // Out-of-range values are ignored and the old value kept.
      // Checking here rather than at restart means software reads back
      // exactly the value that a later restart will apply, save an all-zero 32-bit denominator, applied as one.
      unique case (reg_addr)
        // A zero 16-bit part would stall the gear or divide by zero
        `PEG_OFS_G16_NUM: begin
          if (reg_wdata[15:0] != 16'h0000) gear16_numerator_reg <= reg_wdata[15:0];
        end
        `PEG_OFS_G16_DEN: begin
          if (reg_wdata[15:0] != 16'h0000) gear16_denominator_reg <= reg_wdata[15:0];
        end
        // Decimal halves above the largest four-digit value are refused
        `PEG_OFS_G32_NUM_HI: begin
          if (reg_wdata <= `PEG_G32_PART_MAX) begin
            gear32_numerator_high_reg <= reg_wdata[15:0];
          end
        end
        `PEG_OFS_G32_NUM_LO: begin
          if (reg_wdata <= `PEG_G32_PART_MAX) begin
            gear32_numerator_low_reg <= reg_wdata[15:0];
          end
        end
        `PEG_OFS_G32_DEN_HI: begin
          if (reg_wdata <= `PEG_G32_PART_MAX) begin
            gear32_denominator_high_reg <= reg_wdata[15:0];
          end
        end
        `PEG_OFS_G32_DEN_LO: begin
          if (reg_wdata <= `PEG_G32_PART_MAX) begin
            gear32_denominator_low_reg <= reg_wdata[15:0];
          end
        end
        `PEG_OFS_CONFIG: begin
          // Code 2'b11 is not a mode; writes carrying it keep the old mode
          if (reg_wdata[1:0] != 2'b11) config_reg <= reg_wdata[2:0];
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Restart: staged ratio and mode become active
  // The swap waits for an idle divider; a pulse in flight finishes with
  // the ratio that it started with, so no count is ever split.
  // Divider handshake: start for one cycle, done for one cycle
  logic div_busy;
  logic div_done;
  logic [63:0] div_q;
  logic [63:0] div_r;
  logic div_start;
  logic [31:0] acc_reg; // Fractional remainder, below the act_den of the division that left it
  logic pending_reg; // A pulse is being divided

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      restart_req_reg <= 1'b0;
      // After reset the gear is one to one and clears on servo-off
      act_num_reg <= 32'h0000_0001;
      act_den_reg <= 32'h0000_0001;
      act_mode_reg <= PEG_CLR_SOFF;
    end else begin
      if (reg_write && reg_addr == `PEG_OFS_RESTART && reg_wdata[0]) begin
        restart_req_reg <= 1'b1;
      end else if (restart_req_reg && !pending_reg) begin
        // Wait for an idle gear so no pulse sees a half-switched ratio
        restart_req_reg <= 1'b0;
        act_mode_reg <= peg_clr_mode_t'(config_reg[1:0]);
        if (config_reg[`PEG_CFG_WIDTH_BIT]) begin
          act_num_reg <= num32_w;
          // All-zero halves would divide by zero; fall back to one
          act_den_reg <= (den32_w == 32'h0) ? 32'h0000_0001 : den32_w;
        end else begin
          act_num_reg <= num16_w;
          act_den_reg <= den16_w;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Clear decision
  // The active mode is used, so a staged mode change does not alter
  // clearing until restart. Code 3 is refused at the register, so the
  // default arm only guards a value that cannot be stored.
  logic clear_auto; // Automatic clear by mode
  logic clear_now; // Any clear this cycle
  always_comb begin
    unique case (act_mode_reg)
      PEG_CLR_SOFF: clear_auto = !servo_on;
      PEG_CLR_NONE: clear_auto = 1'b0;
      PEG_CLR_SOFF_OT: clear_auto = !servo_on || (over_travel && !zero_clamp_stop);
      default: clear_auto = 1'b0;
    endcase
  end
  // The external clear is honoured in every mode, no-clear included
  assign clear_now = !error_clear_n || clear_auto;

  ////////////////////////////////////////////////////////////////
  // Pulse edge detection and geared step
  // The previous level resets low to match an idle host line, so the
  // release of reset never shows a false edge. Direction is latched
  // with the edge because the host may change it once the pulse is in.
  logic pulse_d_reg; // Previous pulse level
  logic dir_reg; // Direction taken with the pulse
  logic pulse_rise;
  assign pulse_rise = reference_pulse_input && !pulse_d_reg;
  // Pulses arriving while a division runs are dropped and flagged;
  // the division takes about 66 cycles, far below the pulse spacing.
  assign div_start = pulse_rise && !pending_reg && !clear_now;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pulse_d_reg <= 1'b0;
      pending_reg <= 1'b0;
      dir_reg <= 1'b0;
      pulse_refused <= 1'b0;
    end else begin
      pulse_d_reg <= reference_pulse_input;
      // Flag a dropped edge for one cycle so software can count losses
      pulse_refused <= pulse_rise && pending_reg;
      // Start and done never meet: a start needs an idle divider
      if (div_start) begin
        pending_reg <= 1'b1;
        dir_reg <= reference_direction;
      end else if (div_done) begin
        pending_reg <= 1'b0;
      end
    end
  end

  // Each pulse is one reference unit: (acc + num) / den encoder counts
  // A 64-bit divider covers acc + num up to 2^33 with room to spare; the
  // price is about 66 cycles per pulse, which sets the minimum pulse spacing.
  // A narrower divider would allow faster trains but less ratio headroom.
  peg_divider #(
    .W(64)
  ) u_div (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .start(div_start),
    .dividend({32'h0, acc_reg} + {32'h0, act_num_reg}),
    .divisor({32'h0, act_den_reg}),
    .busy(div_busy),
    .done(div_done),
    .quotient(div_q),
    .remainder(div_r)
  );

  // Remainder is carried to the next pulse; a clear discards it
  // Without the carry a ratio such as 3/2 would lose half a count on
  // every pulse and the position would drift over a long train.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_reg <= 32'h0;
    end else if (clear_now) begin
      acc_reg <= 32'h0;
    end else if (div_done) begin
      acc_reg <= div_r[31:0];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Error counter
  // All counts are quadrature edges, four per encoder line, so one
  // revolution is 32768 * 4 counts. The counter wraps on overflow; the
  // loop is expected to keep the following error far below its range.
  logic signed [ERR_W-1:0] step_w; // Signed geared step
  logic signed [ERR_W-1:0] fb_w; // Sign-extended feedback
  assign step_w = !div_done ? '0 :
                  (dir_reg ? ERR_W'(div_q) : -ERR_W'(div_q));
  assign fb_w = ERR_W'(feedback_counts);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      position_error <= '0;
    end else if (clear_now) begin
      // Clear wins over a step arriving in the same cycle
      position_error <= '0;
    end else begin
      position_error <= position_error + step_w - fb_w;
    end
  end

  // Loop runs only when the external clear is not held
  // Registered so the enable changes in the same cycle as the zeroed
  // error; the loop never sees a stale error with the enable set.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      loop_enable <= 1'b0;
    end else begin
      loop_enable <= error_clear_n;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Register reads, data one cycle after the strobe
  // Unmapped offsets and the write-only restart word read zero; the data
  // return to zero outside the answer cycle so a shared bus stays clean.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_read) begin
      unique case (reg_addr)
        `PEG_OFS_G16_NUM: reg_rdata <= {16'h0, gear16_numerator_reg};
        `PEG_OFS_G16_DEN: reg_rdata <= {16'h0, gear16_denominator_reg};
        `PEG_OFS_G32_NUM_HI: reg_rdata <= {16'h0, gear32_numerator_high_reg};
        `PEG_OFS_G32_NUM_LO: reg_rdata <= {16'h0, gear32_numerator_low_reg};
        `PEG_OFS_G32_DEN_HI: reg_rdata <= {16'h0, gear32_denominator_high_reg};
        `PEG_OFS_G32_DEN_LO: reg_rdata <= {16'h0, gear32_denominator_low_reg};
        `PEG_OFS_CONFIG: reg_rdata <= {29'h0, config_reg};
        // Status: restart pending, clear active, divider busy, mode none
        `PEG_OFS_STATUS: reg_rdata <= {28'h0, restart_req_reg, clear_now,
                                       div_busy, act_mode_reg == PEG_CLR_NONE};
        `PEG_OFS_ERROR: reg_rdata <= 32'(position_error);
        default: reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end
endmodule

// ==== logic/peg_regs.svh ====
`ifndef PEG_REGS_SVH
`define PEG_REGS_SVH
// Register offsets on the plain register port
`define PEG_OFS_G16_NUM 8'h00
`define PEG_OFS_G16_DEN 8'h04
`define PEG_OFS_G32_NUM_HI 8'h08
`define PEG_OFS_G32_NUM_LO 8'h0c
`define PEG_OFS_G32_DEN_HI 8'h10
`define PEG_OFS_G32_DEN_LO 8'h14
`define PEG_OFS_CONFIG 8'h18
`define PEG_OFS_STATUS 8'h1c
`define PEG_OFS_ERROR 8'h20
`define PEG_OFS_RESTART 8'h24
// Field positions in the config register
`define PEG_CFG_CLR_MODE_LSB 0
`define PEG_CFG_CLR_MODE_MSB 1
`define PEG_CFG_WIDTH_BIT 2
// Reset values
`define PEG_RST_G16_NUM 16'h0001
`define PEG_RST_G16_DEN 16'h0001
`define PEG_RST_G32_HI 16'h0000
`define PEG_RST_G32_LO 16'h0001
`define PEG_RST_CONFIG 3'h0
// Decimal weight of a 32-bit gear high part
`define PEG_DEC_WEIGHT 32'h0000_2710
// Largest decimal half accepted for a 32-bit gear part
`define PEG_G32_PART_MAX 32'h0000_270f
// Encoder lines per revolution, quadrature counted four times
`define PEG_ENC_LINES 32'h0000_8000
`define PEG_QUAD_MULT 32'h0000_0004
`endif

// ==== logic/peg_pkg.sv ====
package peg_pkg;
  // Automatic clear behaviour of the error counter
  typedef enum logic [1:0] {
    PEG_CLR_SOFF = 2'b00,
    PEG_CLR_NONE = 2'b01,
    PEG_CLR_SOFF_OT = 2'b10
  } peg_clr_mode_t;
  // Divider sequencer states
  typedef enum logic [1:0] {
    PEG_DIV_IDLE = 2'b00,
    PEG_DIV_RUN = 2'b01,
    PEG_DIV_DONE = 2'b10
  } peg_div_state_t;
endpackage

// ==== logic/peg_divider.sv ====
// Restoring divider, one quotient bit per cycle
module peg_divider import peg_pkg::*; #(
  parameter int W = 64
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [W-1:0] dividend,
  input wire logic [W-1:0] divisor,
  output logic busy,
  output logic done,
  output logic [W-1:0] quotient,
  output logic [W-1:0] remainder
);
  localparam int CW = $clog2(W + 1);
  peg_div_state_t state_reg;
  logic [CW-1:0] count_reg; // Bits still to produce
  logic [W-1:0] den_reg; // Latched divisor
  logic [W:0] trial; // Shifted partial remainder

  assign trial = {remainder, quotient[W-1]};
  assign busy = (state_reg == PEG_DIV_RUN);

  ////////////////////////////////////////////////////////////////
  // Sequencer and datapath
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= PEG_DIV_IDLE;
      count_reg <= '0;
      den_reg <= '0;
      quotient <= '0;
      remainder <= '0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state_reg)
        PEG_DIV_IDLE: begin
          if (start) begin
            // Zero divisor is never passed in: the active denominator is kept nonzero
            den_reg <= divisor;
            quotient <= dividend;
            remainder <= '0;
            count_reg <= CW'(W);
            state_reg <= PEG_DIV_RUN;
          end
        end
        PEG_DIV_RUN: begin
          if (trial >= {1'b0, den_reg}) begin
            remainder <= W'(trial - {1'b0, den_reg});
            quotient <= {quotient[W-2:0], 1'b1};
          end else begin
            remainder <= trial[W-1:0];
            quotient <= {quotient[W-2:0], 1'b0};
          end
          count_reg <= count_reg - 1'b1;
          if (count_reg == CW'(1)) begin
            state_reg <= PEG_DIV_DONE;
          end
        end
        PEG_DIV_DONE: begin
          done <= 1'b1;
          state_reg <= PEG_DIV_IDLE;
        end
        default: begin
          state_reg <= PEG_DIV_IDLE;
        end
      endcase
    end
  end
endmodule

// ==== testbench/peg_gear_monitor.sv ====
module peg_gear_monitor #(
  parameter int ERR_W = 32,
  parameter int FB_W = 8
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic reference_pulse_input,
  input wire logic error_clear_n,
  input wire logic servo_on,
  input wire logic over_travel,
  input wire logic signed [FB_W-1:0] feedback_counts,
  input wire logic reg_read,
  input wire logic reg_write,
  input wire logic [31:0] reg_rdata,
  input wire logic signed [ERR_W-1:0] position_error,
  input wire logic loop_enable,
  input wire logic pulse_refused
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  // Cycles since the last pulse rise, saturating; 127 means quiet
  logic [6:0] since_rise;
  // Restarted on every rise so a late divider result is never mistaken
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      since_rise <= 7'h7f;
    else if ($rose(reference_pulse_input))
      since_rise <= 7'h00;
    else if (since_rise != 7'h7f)
      since_rise <= since_rise + 7'h01;
  end
  ////////////////////////////////////////
  // Clear held over two edges
  sequence clear_held;
    !error_clear_n [*2];
  endsequence
  // Quiet cycle with no clear cause at all
  sequence quiet_step;
    since_rise > 7'h5a && error_clear_n && $past(error_clear_n) && $past(servo_on)
      && !$past(over_travel) && !$past(reg_write);
  endsequence
  clear_zero_a: assert property (!error_clear_n |=> position_error == '0)
    else $error("error counter not zeroed by clear");
  clear_hold_a: assert property (clear_held |-> position_error == '0 && !loop_enable)
    else $error("error or loop active while clear held");
  loop_off_a: assert property ($fell(error_clear_n) |=> !loop_enable)
    else $error("loop still enabled after clear");
  loop_on_a: assert property ($rose(error_clear_n) |=> loop_enable)
    else $error("loop not enabled after clear release");
  rdata_idle_a: assert property (!reg_read |=> reg_rdata == 32'h0)
    else $error("read data outside read answer cycle");
  refuse_once_a: assert property (pulse_refused |=> !pulse_refused)
    else $error("refusal longer than one cycle");
  refuse_cause_a: assert property (pulse_refused |-> since_rise < 7'h04)
    else $error("refusal without pulse edge");
  fb_sub_a: assert property (quiet_step |->
    position_error == $past(position_error) - $past(feedback_counts))
    else $error("feedback not subtracted");
endmodule

bind peg_gear_core peg_gear_monitor #(.ERR_W(ERR_W), .FB_W(FB_W)) mon (
  .core_clk(core_clk),
  .reset_n(reset_n),
  .reference_pulse_input(reference_pulse_input),
  .error_clear_n(error_clear_n),
  .servo_on(servo_on),
  .over_travel(over_travel),
  .feedback_counts(feedback_counts),
  .reg_read(reg_read),
  .reg_write(reg_write),
  .reg_rdata(reg_rdata),
  .position_error(position_error),
  .loop_enable(loop_enable),
  .pulse_refused(pulse_refused)
);

// ==== testbench/peg_host_model.sv ====
// Host controller sending sign plus pulse trains
module peg_host_model (
  output logic pulse_out,
  output logic dir_out,
  input wire logic core_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    pulse_out = 1'b0;
    dir_out = 1'b1;
  end
  // Gap under 61 cycles lands inside a division and is refused
  task automatic send(input int n, input logic fwd, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      dir_out <= fwd;
      @(posedge core_clk);
      pulse_out <= 1'b1;
      repeat (4) @(posedge core_clk);
      pulse_out <= 1'b0;
      repeat (gap) @(posedge core_clk);
    end
  endtask
endmodule

// ==== testbench/position_error_clear_and_gear_tb.sv ====
`include "peg_regs.svh"
module position_error_clear_and_gear_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, reset_n, pulse, dir, clr_n, servo_on, ot, zc, wr, rd, loop_en, refused;
  logic signed [7:0] fb;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic signed [31:0] perr;
  int fail_count, n_compared, n_ref;
  // Reset image of the gear registers and config
  logic [31:0] rst_img [7] = '{32'h1, 32'h1, 32'h0, 32'h1, 32'h0, 32'h1, 32'h0};
  int num32;
  peg_gear_core dut (.core_clk(core_clk), .reset_n(reset_n),
    .reference_pulse_input(pulse), .reference_direction(dir), .error_clear_n(clr_n),
    .servo_on(servo_on), .over_travel(ot), .zero_clamp_stop(zc), .feedback_counts(fb),
    .reg_addr(addr), .reg_wdata(wdata), .reg_write(wr), .reg_read(rd),
    .reg_rdata(rdata), .position_error(perr), .loop_enable(loop_en),
    .pulse_refused(refused));
  peg_host_model host (.pulse_out(pulse), .dir_out(dir), .core_clk(core_clk));
  ////////////////////////////////////////
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  // Read answer stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task automatic pulse_clear();
    clr_n <= 1'b0;
    cyc(2);
    clr_n <= 1'b1;
    cyc(2);
  endtask
  ////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Whole run needs about 1500 cycles
  initial begin
    cyc(20000);
    fail_count++;
    give_verdict();
  end
  always @(posedge core_clk) if (refused === 1'b1) n_ref++;
  initial begin
    {reset_n, zc, ot, wr, rd, fb, addr, wdata} = '0;
    {clr_n, servo_on} = 2'b11;
    cyc(12);
    reset_n <= 1'b1;
    for (int i = 0; i < 7; i++) rd_chk(8'(i * 4), rst_img[i]);
    rd_chk(8'h30, 32'h0);
    host.send(3, 1'b1, 75);
    chk(perr, 3);
    host.send(2, 1'b0, 75);
    chk(perr, 1);
    // Wait until the monitor's quiet window opens before feedback
    cyc(12);
    @(posedge core_clk);
    fb <= 8'sh02;
    cyc(4);
    fb <= 8'sh00;
    cyc(2);
    chk(perr, -7);
    clr_n <= 1'b0;
    host.send(1, 1'b1, 75);
    chk(perr, 0);
    chk(loop_en, 0);
    clr_n <= 1'b1;
    cyc(2);
    chk(loop_en, 1);
    host.send(1, 1'b1, 75);
    ot <= 1'b1;
    cyc(3);
    chk(perr, 1);
    ot <= 1'b0;
    servo_on <= 1'b0;
    cyc(3);
    chk(perr, 0);
    servo_on <= 1'b1;
    wr_reg(`PEG_OFS_CONFIG, 32'h1);
    wr_reg(`PEG_OFS_RESTART, 32'h1);
    rd_chk(`PEG_OFS_STATUS, 32'h1);
    host.send(1, 1'b1, 75);
    servo_on <= 1'b0;
    cyc(3);
    chk(perr, 1);
    pulse_clear();
    chk(perr, 0);
    servo_on <= 1'b1;
    wr_reg(`PEG_OFS_CONFIG, 32'h3);
    rd_chk(`PEG_OFS_CONFIG, 32'h1);
    wr_reg(`PEG_OFS_CONFIG, 32'h2);
    wr_reg(`PEG_OFS_RESTART, 32'h1);
    host.send(1, 1'b1, 75);
    zc <= 1'b1;
    ot <= 1'b1;
    cyc(3);
    chk(perr, 1);
    ot <= 1'b0;
    zc <= 1'b0;
    cyc(1);
    ot <= 1'b1;
    cyc(3);
    chk(perr, 0);
    ot <= 1'b0;
    // Ratio 3/2 stays inside the 16-bit gear registers' allowed range
    wr_reg(`PEG_OFS_CONFIG, 32'h0);
    wr_reg(`PEG_OFS_G16_NUM, 32'h3);
    wr_reg(`PEG_OFS_G16_DEN, 32'h2);
    wr_reg(`PEG_OFS_G16_NUM, 32'h0);
    rd_chk(`PEG_OFS_G16_NUM, 32'h3);
    host.send(1, 1'b1, 75);
    chk(perr, 1);
    wr_reg(`PEG_OFS_RESTART, 32'h1);
    host.send(3, 1'b1, 75);
    chk(perr, 5);
    host.send(2, 1'b1, 10);
    cyc(80);
    chk(perr, 7);
    chk(n_ref, 1);
    rd_chk(`PEG_OFS_ERROR, 32'h7);
    // One revolution of counts per 6000 units, split into decimal halves
    num32 = `PEG_ENC_LINES * `PEG_QUAD_MULT;
    wr_reg(`PEG_OFS_G32_NUM_HI, num32 / `PEG_DEC_WEIGHT);
    wr_reg(`PEG_OFS_G32_NUM_LO, num32 % `PEG_DEC_WEIGHT);
    wr_reg(`PEG_OFS_G32_DEN_HI, 32'h0);
    wr_reg(`PEG_OFS_G32_DEN_LO, 32'd6000);
    wr_reg(`PEG_OFS_G32_DEN_LO, 32'd10000);
    rd_chk(`PEG_OFS_G32_DEN_LO, 32'd6000);
    wr_reg(`PEG_OFS_CONFIG, 32'h4);
    wr_reg(`PEG_OFS_RESTART, 32'h1);
    pulse_clear();
    host.send(2, 1'b1, 75);
    chk(perr, (2 * num32) / 6000);
    give_verdict();
  end
endmodule
